// ===== hw/ffr_device.sv
// Purpose: fifo end with standard and fall-through flags and retransmit
// Assumes: write and read agents run on ref_clk, so skew minimums always hold
// Notes: all flags active low; straps are caught while master reset is low
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ffr_map.svh"
//
// Contract
// - standard empty flag rises one cycle after write
// - standard first word readable after one cycle
// - fall-through first word shown within two cycles
// - output-ready asserts one cycle after fetch
// - input-ready asserts one cycle after read
// - almost-full releases one cycle after read
// - almost-empty releases one cycle after write
// - reader waits for empty flag after retransmit
// - standard retransmit needs two writes, two reads
// - fall-through retransmit needs two writes
// - mode select high means normal retransmit
// - mode select low means zero-latency retransmit
// - standard zero-latency retransmit updates empty flag
// - fall-through zero-latency retransmit updates output-ready
// - data driven only while output enable low
// - nine-bit ports: offset top bit 17/18
// - other widths: offset top bit 16/17
// - standard depth 131072 words here
// - fall-through depth one word greater
// - empty flag low when empty, reads ignored
// - output-ready rises when last word consumed
module ffr_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // link to the writing and reading agent
  ffr_link_if.dev link,
  // local status
  output var ffr_pkg::ffr_count_t fillLevel_reg,
  output logic retransmitBusy_reg
);
  import ffr_pkg::*;

  localparam logic [5:0] LAST_EMPTY_BIT = 6'(`FFR_OFS_TOP);
  localparam logic [5:0] LAST_LOAD_BIT = 6'(2 * `FFR_OFS_TOP + 1);
  localparam ffr_count_t ONE = 18'h00001;

  ffr_word_t mem [0:`FFR_DEPTH-1];
  logic [`FFR_ADDR_W-1:0] wrPtr_reg;
  logic [`FFR_ADDR_W-1:0] rdPtr_reg;
  ffr_count_t memCount_reg;
  ffr_count_t memCount_next;
  ffr_count_t written_reg;
  ffr_count_t occupancy;
  logic first_word_fallthrough_mode_reg;
  logic rtNormal_reg;
  logic outValid_reg;
  logic [`FFR_OFS_W-1:0] emptyOfs_reg;
  logic [`FFR_OFS_W-1:0] fullOfs_reg;
  logic [5:0] loadIdx_reg;
  logic [1:0] setupCnt_reg;
  ffr_rt_e rtState_reg;
  logic anyReset;
  logic rtSetup;
  logic doRetransmit;
  logic rtZero;
  logic doWrite;
  logic doRead;
  logic doConsume;
  logic doFetch;
  logic efNext;
  logic orNext;
  logic paeNext;
  logic pafNext;
  logic hfNext;

  assign anyReset = !link.masterResetN || !link.partialResetN;
  assign rtSetup = (rtState_reg == FFR_RT_SETUP);
  assign doRetransmit = !link.retransmitStrobeN && !anyReset && !rtSetup;
  assign rtZero = doRetransmit && !rtNormal_reg;
  // a write while full is dropped; the agent sees the full flag first
  assign doWrite = !link.writeEnableN && link.offsetLoadSelN && !anyReset
    && (memCount_reg != `FFR_DEPTH);
  assign doRead = !first_word_fallthrough_mode_reg && !link.readEnableN && link.emptyFlagN && (memCount_reg != '0)
    && !doRetransmit && !rtSetup && !anyReset;
  assign doConsume = first_word_fallthrough_mode_reg && !link.readEnableN && outValid_reg && !doRetransmit && !rtSetup;
  assign doFetch = first_word_fallthrough_mode_reg && (memCount_reg != '0) && (!outValid_reg || doConsume)
    && !doRetransmit && !rtSetup && !anyReset;
  assign occupancy = memCount_reg + ffr_count_t'(outValid_reg);

  // straps sampled only while master reset is held
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_word_fallthrough_mode_reg <= 1'b0;
      rtNormal_reg <= 1'b0;
    end else if (!link.masterResetN) begin
      first_word_fallthrough_mode_reg <= link.firstWordFallthroughMode;
      rtNormal_reg <= link.retransmitModeSel;
    end
  end

  always_comb begin
    memCount_next = memCount_reg;
    if (doRetransmit) begin
      memCount_next = rtZero ? written_reg - ONE : written_reg;
    end else if (doRead || doFetch) begin
      memCount_next = memCount_reg - ONE;
    end
    if (doWrite) begin
      memCount_next = memCount_next + ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memCount_reg <= '0;
    end else if (anyReset) begin
      memCount_reg <= '0;
    end else begin
      memCount_reg <= memCount_next;
    end
  end

  // written_reg saturates at depth; the writer stops at depth minus two until a retransmit
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      written_reg <= '0;
    end else if (anyReset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      written_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
        written_reg <= (written_reg == `FFR_DEPTH) ? written_reg : written_reg + ONE;
      end
      if (doRetransmit) begin
        rdPtr_reg <= rtZero ? `FFR_ADDR_W'(1) : '0;
      end else if (doRead || doFetch) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= link.writeData;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.dataOut <= '0;
    end else if (!link.masterResetN) begin
      link.dataOut <= '0;
    end else if (rtZero) begin
      link.dataOut <= mem[0];
    end else if (doRead || doFetch) begin
      link.dataOut <= mem[rdPtr_reg];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outValid_reg <= 1'b0;
    end else if (anyReset) begin
      outValid_reg <= 1'b0;
    end else if (doRetransmit) begin
      outValid_reg <= rtZero && first_word_fallthrough_mode_reg;
    end else if (doFetch) begin
      outValid_reg <= 1'b1;
    end else if (doConsume) begin
      outValid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.dataOutEn <= 1'b0;
    end else begin
      link.dataOutEn <= !link.outputEnableN;
    end
  end

  // normal retransmit holds the read side idle for a fixed setup time
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtState_reg <= FFR_RT_IDLE;
      setupCnt_reg <= '0;
    end else if (anyReset) begin
      rtState_reg <= FFR_RT_IDLE;
      setupCnt_reg <= '0;
    end else begin
      case (rtState_reg)
        FFR_RT_IDLE: begin
          setupCnt_reg <= '0;
          if (doRetransmit && rtNormal_reg) begin
            rtState_reg <= FFR_RT_SETUP;
          end
        end
        FFR_RT_SETUP: begin
          setupCnt_reg <= setupCnt_reg + 2'h1;
          if (setupCnt_reg == `FFR_RT_SETUP_CYC - 2'h1) begin
            rtState_reg <= FFR_RT_IDLE;
          end
        end
        default: rtState_reg <= FFR_RT_IDLE;
      endcase
    end
  end

  // serial offsets: empty offset bits first, lsb first, then full offset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      emptyOfs_reg <= `FFR_OFS_DEFAULT;
      fullOfs_reg <= `FFR_OFS_DEFAULT;
      loadIdx_reg <= '0;
    end else if (!link.masterResetN) begin
      emptyOfs_reg <= `FFR_OFS_DEFAULT;
      fullOfs_reg <= `FFR_OFS_DEFAULT;
      loadIdx_reg <= '0;
    end else if (!link.offsetLoadSelN && !link.writeEnableN) begin
      if (loadIdx_reg <= LAST_EMPTY_BIT) begin
        emptyOfs_reg[5'(loadIdx_reg)] <= link.serialIn;
      end else begin
        fullOfs_reg[5'(loadIdx_reg - LAST_EMPTY_BIT - 6'h01)] <= link.serialIn;
      end
      loadIdx_reg <= (loadIdx_reg == LAST_LOAD_BIT) ? 6'h00 : loadIdx_reg + 6'h01;
    end
  end

  // flags follow registered counts, so each lags its cause by one cycle, except empty and output-ready on a zero-latency retransmit
  always_comb begin
    efNext = (memCount_reg != '0) && !rtSetup;
    orNext = !outValid_reg || rtSetup;
    if (rtZero) begin
      efNext = (memCount_next != '0);
      orNext = !first_word_fallthrough_mode_reg;
    end
    if (first_word_fallthrough_mode_reg) begin
      paeNext = occupancy > ffr_count_t'(emptyOfs_reg) + ONE;
      pafNext = occupancy < `FFR_DEPTH_FIRST_WORD_FALLTHROUGH_MODE - ffr_count_t'(fullOfs_reg);
      hfNext = occupancy <= `FFR_HALF + ONE;
    end else begin
      paeNext = memCount_reg > ffr_count_t'(emptyOfs_reg);
      pafNext = memCount_reg < `FFR_DEPTH - ffr_count_t'(fullOfs_reg);
      hfNext = memCount_reg <= `FFR_HALF;
    end
  end

  ffr_flag_stage #(.RESET_VAL(1'b0)) efStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(efNext), .flag_reg(link.emptyFlagN)
  );
  ffr_flag_stage #(.RESET_VAL(1'b1)) orStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(orNext), .flag_reg(link.outputReadyN)
  );
  ffr_flag_stage #(.RESET_VAL(1'b1)) ffStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(memCount_reg != `FFR_DEPTH), .flag_reg(link.fullFlagN)
  );
  ffr_flag_stage #(.RESET_VAL(1'b0)) irStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(occupancy == `FFR_DEPTH_FIRST_WORD_FALLTHROUGH_MODE), .flag_reg(link.inputReadyN)
  );
  ffr_flag_stage #(.RESET_VAL(1'b0)) paeStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(paeNext), .flag_reg(link.almostEmptyFlagN)
  );
  ffr_flag_stage #(.RESET_VAL(1'b1)) pafStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(pafNext), .flag_reg(link.almostFullFlagN)
  );
  ffr_flag_stage #(.RESET_VAL(1'b1)) hfStage (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clear(anyReset),
    .flagNext(hfNext), .flag_reg(link.halfFullFlagN)
  );

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fillLevel_reg <= '0;
      retransmitBusy_reg <= 1'b0;
    end else begin
      fillLevel_reg <= occupancy;
      retransmitBusy_reg <= rtSetup;
    end
  end
endmodule // ffr_device
`default_nettype wire

// ===== hw/ffr_flag_stage.sv
// Purpose: one registered status flag
// Assumes: clear is synchronous and wins over the next value
// Notes: reset value is the flag's idle level after any reset
`timescale 1ns/100ps
`default_nettype none
module ffr_flag_stage #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic clear,
  input wire logic flagNext,
  // flag
  output logic flag_reg
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= RESET_VAL;
    end else if (clear) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flagNext;
    end
  end
endmodule // ffr_flag_stage
`default_nettype wire

// ===== hw/ffr_host.sv
// Purpose: controller driving the fifo pins on orders from an apb slave
// Assumes: apb with zero wait states beyond the registered answer
// Notes: each accepted order pulses the matching pin for exactly one cycle
`timescale 1ns/100ps
`default_nettype none
`include "ffr_map.svh"
module ffr_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // fifo pins
  ffr_link_if.host link
);
  import ffr_pkg::*;

  logic [5:0] cfg_reg;
  ffr_word_t rdata_reg;
  ffr_count_t wrSinceRst_reg;
  logic [1:0] wrSeen_reg;
  logic [1:0] rdSeen_reg;
  logic rtDone_reg;
  logic setupPh;
  logic commitWr;
  logic pinReset;
  logic wrAllowed;
  logic rdAllowed;
  logic rtAllowed;
  logic goWrite;
  logic goRead;
  logic goRt;

  assign setupPh = psel && !penable;
  assign commitWr = psel && penable && pready && pwrite;
  assign pinReset = cfg_reg[`FFR_CFG_MRST] || cfg_reg[`FFR_CFG_PRST];
  assign wrAllowed = rtDone_reg || (wrSinceRst_reg < `FFR_WR_LIMIT);
  assign rdAllowed = cfg_reg[`FFR_CFG_FIRST_WORD_FALLTHROUGH_MODE] || link.emptyFlagN;
  assign rtAllowed = (wrSeen_reg == 2'h2) && (cfg_reg[`FFR_CFG_FIRST_WORD_FALLTHROUGH_MODE] || rdSeen_reg == 2'h2);
  assign goWrite = commitWr && (paddr == `FFR_ADDR_WDATA) && (cfg_reg[`FFR_CFG_LOAD] || wrAllowed);
  assign goRead = commitWr && (paddr == `FFR_ADDR_RCMD) && pwdata[`FFR_CMD_READ] && rdAllowed;
  assign goRt = commitWr && (paddr == `FFR_ADDR_RCMD) && pwdata[`FFR_CMD_RT] && rtAllowed;

  // answer is prepared in the setup cycle so pready can come from a flop
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPh;
      pslverr <= 1'b0;
      prdata <= '0;
      if (setupPh) begin
        case (paddr)
          `FFR_ADDR_CFG: prdata <= {26'h0, cfg_reg};
          `FFR_ADDR_WDATA: prdata <= '0;
          `FFR_ADDR_RCMD: prdata <= '0;
          `FFR_ADDR_STATUS: prdata <= {25'h0, link.halfFullFlagN, link.almostFullFlagN,
            link.almostEmptyFlagN, link.inputReadyN, link.fullFlagN, link.outputReadyN, link.emptyFlagN};
          `FFR_ADDR_RDATA: prdata <= {14'h0, rdata_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= `FFR_CFG_RESET;
    end else if (commitWr && paddr == `FFR_ADDR_CFG) begin
      cfg_reg <= pwdata[5:0];
    end
  end

  // level pins follow the configuration one cycle later
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.masterResetN <= 1'b1;
      link.partialResetN <= 1'b1;
      link.firstWordFallthroughMode <= 1'b0;
      link.retransmitModeSel <= 1'b0;
      link.outputEnableN <= 1'b1;
      link.offsetLoadSelN <= 1'b1;
    end else begin
      link.masterResetN <= !cfg_reg[`FFR_CFG_MRST];
      link.partialResetN <= !cfg_reg[`FFR_CFG_PRST];
      link.firstWordFallthroughMode <= cfg_reg[`FFR_CFG_FIRST_WORD_FALLTHROUGH_MODE];
      link.retransmitModeSel <= cfg_reg[`FFR_CFG_RTNORM];
      link.outputEnableN <= !cfg_reg[`FFR_CFG_OE];
      link.offsetLoadSelN <= !cfg_reg[`FFR_CFG_LOAD];
    end
  end

  // one-cycle strobes; serial offset bits ride on data bit 0
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.writeEnableN <= 1'b1;
      link.readEnableN <= 1'b1;
      link.retransmitStrobeN <= 1'b1;
      link.writeData <= '0;
      link.serialIn <= 1'b0;
    end else begin
      link.writeEnableN <= !goWrite;
      link.readEnableN <= !goRead;
      link.retransmitStrobeN <= !goRt;
      if (goWrite) begin
        link.writeData <= pwdata[`FFR_DATA_W-1:0];
        link.serialIn <= pwdata[0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrSinceRst_reg <= '0;
      wrSeen_reg <= '0;
      rdSeen_reg <= '0;
      rtDone_reg <= 1'b0;
    end else if (pinReset) begin
      wrSinceRst_reg <= '0;
      wrSeen_reg <= '0;
      rdSeen_reg <= '0;
      rtDone_reg <= 1'b0;
    end else begin
      if (goWrite && !cfg_reg[`FFR_CFG_LOAD]) begin
        wrSinceRst_reg <= wrSinceRst_reg + 18'h00001;
        wrSeen_reg <= (wrSeen_reg == 2'h2) ? wrSeen_reg : wrSeen_reg + 2'h1;
      end
      if (goRead) begin
        rdSeen_reg <= (rdSeen_reg == 2'h2) ? rdSeen_reg : rdSeen_reg + 2'h1;
      end
      if (goRt) begin
        rtDone_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else if (link.dataOutEn) begin
      rdata_reg <= link.dataOut;
    end
  end
endmodule // ffr_host
`default_nettype wire

// ===== hw/ffr_link_if.sv
// Purpose: pins between the fifo and its controlling agent
// Assumes: both ends on ref_clk
// Notes: dataOut is meaningful only while dataOutEn is high
`timescale 1ns/100ps
`default_nettype none
interface ffr_link_if;
  import ffr_pkg::*;
  ffr_word_t writeData;
  logic writeEnableN;
  logic readEnableN;
  logic outputEnableN;
  logic retransmitStrobeN;
  logic masterResetN;
  logic partialResetN;
  logic offsetLoadSelN;
  logic serialIn;
  logic firstWordFallthroughMode;
  logic retransmitModeSel;
  ffr_word_t dataOut;
  logic dataOutEn;
  logic emptyFlagN;
  logic outputReadyN;
  logic fullFlagN;
  logic inputReadyN;
  logic almostEmptyFlagN;
  logic almostFullFlagN;
  logic halfFullFlagN;
  modport dev (
    input writeData, writeEnableN, readEnableN, outputEnableN, retransmitStrobeN,
    input masterResetN, partialResetN, offsetLoadSelN, serialIn,
    input firstWordFallthroughMode, retransmitModeSel,
    output dataOut, dataOutEn, emptyFlagN, outputReadyN, fullFlagN, inputReadyN,
    output almostEmptyFlagN, almostFullFlagN, halfFullFlagN
  );
  modport host (
    output writeData, writeEnableN, readEnableN, outputEnableN, retransmitStrobeN,
    output masterResetN, partialResetN, offsetLoadSelN, serialIn,
    output firstWordFallthroughMode, retransmitModeSel,
    input dataOut, dataOutEn, emptyFlagN, outputReadyN, fullFlagN, inputReadyN,
    input almostEmptyFlagN, almostFullFlagN, halfFullFlagN
  );
endinterface // ffr_link_if
`default_nettype wire

// ===== hw/ffr_map.svh
// Purpose: shared constants of the retransmit fifo link
// Assumes: 18-bit ports, smaller depth variant
// Notes: included by bare name wherever a constant is needed
`ifndef FFR_MAP_SVH
`define FFR_MAP_SVH
`define FFR_DATA_W 18
`define FFR_ADDR_W 17
`define FFR_CNT_W 18
`define FFR_DEPTH 18'h20000
`define FFR_DEPTH_FIRST_WORD_FALLTHROUGH_MODE 18'h20001
`define FFR_HALF 18'h10000
`define FFR_WR_LIMIT 18'h1FFFE
`define FFR_OFS_W 17
`define FFR_OFS_TOP 16
`define FFR_OFS_TOP_9X9 17
`define FFR_OFS_TOP_BIG 17
`define FFR_OFS_TOP_BIG_9X9 18
`define FFR_OFS_DEFAULT 17'h0007F
`define FFR_RT_SETUP_CYC 2'h2
`define FFR_ADDR_CFG 12'h000
`define FFR_ADDR_WDATA 12'h004
`define FFR_ADDR_RCMD 12'h008
`define FFR_ADDR_STATUS 12'h00C
`define FFR_ADDR_RDATA 12'h010
`define FFR_CFG_FIRST_WORD_FALLTHROUGH_MODE 0
`define FFR_CFG_RTNORM 1
`define FFR_CFG_OE 2
`define FFR_CFG_MRST 3
`define FFR_CFG_PRST 4
`define FFR_CFG_LOAD 5
`define FFR_CFG_RESET 6'h00
`define FFR_CMD_READ 0
`define FFR_CMD_RT 1
`endif

// ===== hw/ffr_pkg.sv
// Purpose: types shared by both ends of the retransmit fifo link
// Assumes: ffr_map.svh holds every number
// Notes: none
`include "ffr_map.svh"
package ffr_pkg;
  typedef logic [`FFR_DATA_W-1:0] ffr_word_t;
  typedef logic [`FFR_CNT_W-1:0] ffr_count_t;
  typedef enum {FFR_RT_IDLE, FFR_RT_SETUP} ffr_rt_e;
endpackage

// ===== verif/ffr_link_assertions.sv
// Purpose: concurrent checks on the pins between fifo end and controller
// Assumes: one clock; straps are caught while master reset is low
// Notes: quiet count masks the cycles just after master reset or retransmit
`timescale 1ns/100ps
`default_nettype none
module ffr_link_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // agent to fifo
  input wire ffr_pkg::ffr_word_t writeData,
  input wire logic writeEnableN,
  input wire logic readEnableN,
  input wire logic outputEnableN,
  input wire logic retransmitStrobeN,
  input wire logic masterResetN,
  input wire logic firstWordFallthroughMode,
  input wire logic retransmitModeSel,
  // fifo to agent
  input wire ffr_pkg::ffr_word_t dataOut,
  input wire logic dataOutEn,
  input wire logic emptyFlagN,
  input wire logic outputReadyN,
  input wire logic almostEmptyFlagN
);
  import ffr_pkg::*;
  logic fwftMode_reg;
  logic rtNormal_reg;
  logic haveFirst_reg;
  logic [2:0] quiet_reg;
  ffr_word_t firstWord_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwftMode_reg <= 1'h0;
      rtNormal_reg <= 1'h0;
    end else if (!masterResetN) begin
      fwftMode_reg <= firstWordFallthroughMode;
      rtNormal_reg <= retransmitModeSel;
    end
  end

  // master reset or rewind restarts the count, so flag checks skip transients
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst || !masterResetN || !retransmitStrobeN)
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst || !masterResetN) begin
      haveFirst_reg <= 1'h0;
      firstWord_reg <= '0;
    end else if (!writeEnableN && !haveFirst_reg) begin
      haveFirst_reg <= 1'h1;
      firstWord_reg <= writeData;
    end
  end

  property fallThrough;
    ffr_word_t w;
    (fwftMode_reg && quiet_reg == 3'h7 && dataOutEn && outputReadyN && $past(writeEnableN) && !writeEnableN,
      w = writeData) |=> ##1 dataOut == w ##1 !outputReadyN;
  endproperty

  a_empty_rise_one: assert property (!fwftMode_reg && quiet_reg == 3'h7 && !emptyFlagN && !writeEnableN
    |=> ##1 emptyFlagN) else $error("empty flag late after write");
  a_fall_through_word: assert property (fallThrough)
    else $error("fall-through word or output ready late");
  a_ae_release_write: assert property ($rose(almostEmptyFlagN) && quiet_reg == 3'h7
    |-> !$past(writeEnableN) || !$past(writeEnableN, 2)) else $error("almost-empty released without write");
  a_data_needs_oe: assert property (dataOutEn |-> !$past(outputEnableN))
    else $error("outputs driven without output enable");
  a_empty_data_still: assert property (!fwftMode_reg && masterResetN && retransmitStrobeN && !emptyFlagN
    |=> $stable(dataOut)) else $error("output word moved while empty");
  a_or_rise_on_read: assert property (fwftMode_reg && quiet_reg == 3'h7 && $rose(outputReadyN)
    |-> !$past(readEnableN, 2)) else $error("output ready rose without a read");
  a_zl_rewind_word: assert property (!rtNormal_reg && haveFirst_reg && dataOutEn && !retransmitStrobeN
    |=> dataOut == firstWord_reg && (fwftMode_reg ? !outputReadyN : emptyFlagN))
    else $error("zero-latency rewind did not show first word");
  a_normal_rt_setup: assert property (rtNormal_reg && masterResetN && !retransmitStrobeN
    |-> ##2 (fwftMode_reg ? outputReadyN : !emptyFlagN) ##[1:3] (fwftMode_reg ? !outputReadyN : emptyFlagN))
    else $error("normal retransmit setup length wrong");

  c_zl_rewind: cover property (!rtNormal_reg && !retransmitStrobeN && fwftMode_reg);
  c_normal_rewind: cover property (rtNormal_reg && !retransmitStrobeN);
  c_ae_release: cover property ($rose(almostEmptyFlagN));
endmodule // ffr_link_assertions
`default_nettype wire

// ===== verif/fifo_flag_latency_retransmit_bench.sv
// Purpose: drives the fifo controller over apb against the fifo end
// Assumes: expected words come from a fixed pattern
// Notes: each transfer idles a few cycles so pin pulses reach the status
`timescale 1ns/100ps
`default_nettype none
`include "ffr_map.svh"
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin nFail++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module fifo_flag_latency_retransmit_bench;
  import ffr_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] OE = 32'h1 << `FFR_CFG_OE;
  localparam logic [31:0] FIRST_WORD_FALLTHROUGH_MODE = 32'h1 << `FFR_CFG_FIRST_WORD_FALLTHROUGH_MODE;
  localparam logic [31:0] RTN = 32'h1 << `FFR_CFG_RTNORM;
  logic ref_clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic errSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int nFail;
  int checkCount;
  int cyc;
  ffr_count_t fill;
  logic busy;

  ffr_link_if i_ffr_link_if ();
  ffr_host i_ffr_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .link(i_ffr_link_if));
  ffr_device i_ffr_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(i_ffr_link_if), .fillLevel_reg(fill),
    .retransmitBusy_reg(busy));
  ffr_link_assertions i_ffr_link_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .writeData(i_ffr_link_if.writeData), .writeEnableN(i_ffr_link_if.writeEnableN),
    .readEnableN(i_ffr_link_if.readEnableN), .outputEnableN(i_ffr_link_if.outputEnableN),
    .retransmitStrobeN(i_ffr_link_if.retransmitStrobeN), .masterResetN(i_ffr_link_if.masterResetN),
    .firstWordFallthroughMode(i_ffr_link_if.firstWordFallthroughMode),
    .retransmitModeSel(i_ffr_link_if.retransmitModeSel), .dataOut(i_ffr_link_if.dataOut),
    .dataOutEn(i_ffr_link_if.dataOutEn), .emptyFlagN(i_ffr_link_if.emptyFlagN),
    .outputReadyN(i_ffr_link_if.outputReadyN), .almostEmptyFlagN(i_ffr_link_if.almostEmptyFlagN));

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang in any handshake ends here rather than running on
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      reportAndStop();
    end
  end

  task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic expectRead(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex, input string nm);
    apbXfer(1'h0, a, 32'h0);
    `CHK(nm, ex, rd & m)
  endtask

  // master reset is held over a whole transfer, well past two cycles
  task automatic setMode(input logic [31:0] m);
    apbXfer(1'h1, `FFR_ADDR_CFG, m | (32'h1 << `FFR_CFG_MRST));
    apbXfer(1'h1, `FFR_ADDR_CFG, m);
    repeat (8) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] wv(input int i);
    return {14'h0000, 18'h2A500 + 18'(i)};
  endfunction

  initial begin
    sys_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    expectRead(`FFR_ADDR_CFG, ALL, 32'(`FFR_CFG_RESET), "cfg reset");
    setMode(OE);
    expectRead(`FFR_ADDR_STATUS, 32'h75, 32'h64, "std empty status");
    for (int i = 0; i < 128; i++) begin
      apbXfer(1'h1, `FFR_ADDR_WDATA, wv(i));
      if (i == 126)
        expectRead(`FFR_ADDR_STATUS, 32'h11, 32'h01, "almost empty held");
    end
    expectRead(`FFR_ADDR_STATUS, 32'h11, 32'h11, "almost empty released");
    `CHK("fill level", 18'h00080, fill)
    for (int i = 0; i < 2; i++) begin
      apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
      expectRead(`FFR_ADDR_RDATA, ALL, wv(i), "std read word");
    end
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h2);
    expectRead(`FFR_ADDR_RDATA, ALL, wv(0), "zero-latency first word");
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
    expectRead(`FFR_ADDR_RDATA, ALL, wv(1), "word after rewind");
    apbXfer(1'h0, 12'h020, 32'h0);
    `CHK("unmapped error", 1'h1, errSeen)
    setMode(OE | RTN);
    for (int i = 0; i < 3; i++)
      apbXfer(1'h1, `FFR_ADDR_WDATA, wv(i));
    repeat (2) apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h2);
    // the reader holds off until the empty flag is back high
    do apbXfer(1'h0, `FFR_ADDR_STATUS, 32'h0); while (rd[0] !== 1'h1);
    `CHK("setup over", 1'h0, busy)
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
    expectRead(`FFR_ADDR_RDATA, ALL, wv(0), "normal rewind word");
    setMode(OE | FIRST_WORD_FALLTHROUGH_MODE);
    expectRead(`FFR_ADDR_STATUS, 32'h0A, 32'h02, "first_word_fallthrough_mode empty status");
    apbXfer(1'h1, `FFR_ADDR_WDATA, wv(0));
    apbXfer(1'h1, `FFR_ADDR_WDATA, wv(1));
    expectRead(`FFR_ADDR_RDATA, ALL, wv(0), "fall-through word");
    expectRead(`FFR_ADDR_STATUS, 32'h02, 32'h00, "output ready");
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
    expectRead(`FFR_ADDR_RDATA, ALL, wv(1), "second word shown");
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
    expectRead(`FFR_ADDR_STATUS, 32'h02, 32'h02, "last word taken");
    expectRead(`FFR_ADDR_RDATA, ALL, wv(1), "last word kept");
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h2);
    expectRead(`FFR_ADDR_STATUS, 32'h02, 32'h00, "rewind output ready");
    expectRead(`FFR_ADDR_RDATA, ALL, wv(0), "rewind first word");
    apbXfer(1'h1, `FFR_ADDR_CFG, FIRST_WORD_FALLTHROUGH_MODE);
    apbXfer(1'h1, `FFR_ADDR_RCMD, 32'h1);
    expectRead(`FFR_ADDR_RDATA, ALL, wv(0), "outputs off");
    reportAndStop();
  end
endmodule // fifo_flag_latency_retransmit_bench
`default_nettype wire
